// File: core/sag_pkg.sv
// Purpose: Shared constants and types for the sample activity gating sequencer
// Assumes: One clock pclk at 250 MHz, APB register access
// Notes: Byte offsets of the APB registers and their field positions
`default_nettype none
package sag_pkg;
  // Clock rate
  localparam int unsigned CLK_MHZ = 250;
  // Microsecond tick derived from the clock rate
  localparam int unsigned TICK_US = 1;
  localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_IN_CFG = 8'h04;
  localparam logic [7:0] REG_LEAD = 8'h08;
  localparam logic [7:0] REG_HOLD = 8'h0C;
  localparam logic [7:0] REG_MEAS = 8'h10;
  localparam logic [7:0] REG_CAL_INT = 8'h14;
  localparam logic [7:0] REG_CLN_INT = 8'h18;
  localparam logic [7:0] REG_ACT_LEN = 8'h1C;
  localparam logic [7:0] REG_STATUS = 8'h20;
  localparam logic [7:0] REG_OUT_MAP = 8'h24;
  // Control fields
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_CONT = 1;
  localparam int unsigned CTRL_CH2 = 2;
  // Input configuration fields, per input: enable at 2i, polarity at 2i+1
  localparam int unsigned IN_EN_BIT = 0;
  localparam int unsigned IN_POL_BIT = 1;
  localparam int unsigned IN_SEL_CH0 = 8;
  localparam int unsigned IN_SEL_CH1 = 12;
  localparam logic [31:0] IN_CFG_RESET = 32'h0000_1003;
  // Reset values for timings, in microseconds
  localparam logic [31:0] LEAD_RESET = 32'h0000_0064;
  localparam logic [31:0] HOLD_RESET = 32'h0000_0064;
  localparam logic [31:0] MEAS_RESET = 32'h0000_03E8;
  localparam logic [31:0] CAL_INT_RESET = 32'h0000_2710;
  localparam logic [31:0] CLN_INT_RESET = 32'h0000_4E20;
  localparam logic [31:0] ACT_LEN_RESET = 32'h0000_01F4;
  localparam logic [31:0] OUT_MAP_RESET = 32'h0000_0000;
  // Activity kinds
  typedef enum logic [1:0] {
    ACT_MEAS = 2'b00,
    ACT_CAL = 2'b01,
    ACT_CLN = 2'b10
  } sag_act_type;
  // Channel sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LEAD = 4'b0010,
    ST_RUN = 4'b0100,
    ST_DONE = 4'b1000
  } sag_state_type;
endpackage : sag_pkg
`default_nettype wire

// File: core/sag_chan.sv
// Purpose: One measuring channel sequencer with lead time and sample request
// Assumes: Access level already synchronised, polarised and enabled
// Notes: Times counted in microsecond ticks
`default_nettype none
module sag_chan
  import sag_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire logic tick,
  input wire logic run_en,
  input wire logic cont_mode,
  input wire logic start_req,
  input wire logic access,
  input wire logic [31:0] lead_us,
  input wire logic [31:0] hold_us,
  input wire logic [31:0] meas_us,
  input wire logic [31:0] cal_int_us,
  input wire logic [31:0] cln_int_us,
  input wire logic [31:0] act_len_us,
  // Status
  output logic meas_active,
  output logic sample_req,
  output logic busy,
  output logic [1:0] act_kind
);
  sag_state_type state_q;
  sag_act_type act_q;
  logic [31:0] phase_q;
  logic [31:0] req_q;
  logic [31:0] cal_q;
  logic [31:0] cln_q;
  logic pend_q;
  logic cal_due;
  logic cln_due;
  logic [31:0] hold_lim;
  logic [31:0] act_time;
  logic want;

  assign cal_due = (cal_q >= cal_int_us);
  assign cln_due = (cln_q >= cln_int_us);
  // Duration capped at lead plus measurement time
  assign hold_lim = (hold_us > lead_us + meas_us) ? lead_us + meas_us : hold_us;
  assign act_time = (act_q == ACT_MEAS) ? meas_us : act_len_us;
  // Continuous mode asks for work at once; otherwise a start request is kept
  assign want = cont_mode | pend_q | cal_due | cln_due;

  // Pending single start request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (start_req) begin
      pend_q <= 1'b1;
    end else if (state_q == ST_IDLE && access && run_en && !cal_due && !cln_due) begin
      pend_q <= 1'b0;
    end
  end

  // Interval timers for calibration and cleaning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_q <= 32'h0000_0000;
      cln_q <= 32'h0000_0000;
    end else begin
      if (state_q == ST_DONE && act_q == ACT_CAL) begin
        cal_q <= 32'h0000_0000;
      end else if (tick && !cal_due) begin
        cal_q <= cal_q + 32'h0000_0001;
      end
      if (state_q == ST_DONE && act_q == ACT_CLN) begin
        cln_q <= 32'h0000_0000;
      end else if (tick && !cln_due) begin
        cln_q <= cln_q + 32'h0000_0001;
      end
    end
  end

  // Activity sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      act_q <= ACT_MEAS;
      phase_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          phase_q <= 32'h0000_0000;
          // Start only with access; otherwise hold pending work
          if (run_en && access && want) begin
            // Due calibration first, then cleaning, then measurement
            if (cal_due) begin
              act_q <= ACT_CAL;
            end else if (cln_due) begin
              act_q <= ACT_CLN;
            end else begin
              act_q <= ACT_MEAS;
            end
            state_q <= ST_LEAD;
          end
        end
        ST_LEAD: begin
          // Activity postponed by lead time
          if (phase_q >= lead_us) begin
            state_q <= ST_RUN;
            phase_q <= 32'h0000_0000;
          end else if (tick) begin
            phase_q <= phase_q + 32'h0000_0001;
          end
        end
        ST_RUN: begin
          if (phase_q >= act_time) begin
            state_q <= ST_DONE;
          end else if (tick) begin
            phase_q <= phase_q + 32'h0000_0001;
          end
        end
        ST_DONE: begin
          // Back to idle; next start follows without pause
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Sample request hold counter, started with the lead phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 32'h0000_0000;
      sample_req <= 1'b0;
    end else if (state_q == ST_IDLE && run_en && access && want && hold_lim != 32'h0) begin
      req_q <= 32'h0000_0000;
      sample_req <= 1'b1;
    end else if (sample_req) begin
      if (tick) begin
        req_q <= req_q + 32'h0000_0001;
      end
      if (req_q >= hold_lim) begin
        sample_req <= 1'b0;
      end
    end
  end

  // Measurement running flag, never during calibration or cleaning
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_active <= 1'b0;
      busy <= 1'b0;
      act_kind <= 2'b00;
    end else begin
      meas_active <= (state_q == ST_RUN) && (act_q == ACT_MEAS) && (phase_q < act_time);
      busy <= (state_q != ST_IDLE);
      act_kind <= act_q;
    end
  end
endmodule : sag_chan
`default_nettype wire

// File: core/sag_top.sv
// Purpose: Gates sample activities of up to two channels with access inputs
// Assumes: APB slave on pclk, two binary inputs and two binary outputs
// Notes: Outputs registered; inputs pass a two-stage synchroniser
//
// Chosen here: the APB slave port and the address map.
`default_nettype none
module sag_top
  import sag_pkg::*;
#(
  parameter int unsigned NUM_IN = 2,
  parameter int unsigned NUM_OUT = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Binary inputs from the discrete io module
  input wire logic [NUM_IN-1:0] bin_in,
  // Binary outputs to the discrete io module
  output logic [NUM_OUT-1:0] bin_out
);
  logic [NUM_IN-1:0] sync1_q;
  logic [NUM_IN-1:0] sync2_q;
  logic [NUM_IN-1:0] in_act;
  logic [31:0] ctrl_q;
  logic [31:0] in_cfg_q;
  logic [31:0] lead_q;
  logic [31:0] hold_q;
  logic [31:0] meas_q;
  logic [31:0] cal_int_q;
  logic [31:0] cln_int_q;
  logic [31:0] act_len_q;
  logic [31:0] out_map_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic start_q;
  logic [1:0] start_ch;
  logic [1:0] access;
  logic [1:0] meas_a;
  logic [1:0] samp_r;
  logic [1:0] busy;
  logic [1:0] kind0;
  logic [1:0] kind1;
  logic [3:0] kinds;
  logic [3:0] src;
  logic wr_en;
  logic rd_en;
  logic addr_ok;

  // Two-stage synchroniser for the pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= bin_in;
      sync2_q <= sync1_q;
    end
  end

  // Polarity and enable per input
  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    assign in_act[i] = in_cfg_q[2*i+IN_EN_BIT]
        & ~(sync2_q[i] ^ in_cfg_q[2*i+IN_POL_BIT]);
  end

  // Per channel input assignment; channel 2 only on two-channel units
  assign access[0] = in_act[in_cfg_q[IN_SEL_CH0 +: 1]];
  assign access[1] = ctrl_q[CTRL_CH2] & in_act[in_cfg_q[IN_SEL_CH1 +: 1]];

  // Microsecond tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= TICK_LAST) begin
      tick_cnt_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
      tick_q <= 1'b0;
    end
  end

  // APB decode
  assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= REG_OUT_MAP);
  assign wr_en = psel & penable & pwrite & addr_ok;
  assign rd_en = psel & ~penable & ~pwrite;

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h0000_0000;
      in_cfg_q <= IN_CFG_RESET;
      lead_q <= LEAD_RESET;
      hold_q <= HOLD_RESET;
      meas_q <= MEAS_RESET;
      cal_int_q <= CAL_INT_RESET;
      cln_int_q <= CLN_INT_RESET;
      act_len_q <= ACT_LEN_RESET;
      out_map_q <= OUT_MAP_RESET;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      if (wr_en) begin
        unique case (paddr)
          REG_CTRL: begin
            ctrl_q <= {29'h0, pwdata[2:0]};
            start_q <= pwdata[3];
          end
          REG_IN_CFG: in_cfg_q <= pwdata & 32'h0000_110F;
          REG_LEAD: lead_q <= pwdata;
          REG_HOLD: hold_q <= pwdata;
          REG_MEAS: meas_q <= pwdata;
          REG_CAL_INT: cal_int_q <= pwdata;
          REG_CLN_INT: cln_int_q <= pwdata;
          REG_ACT_LEN: act_len_q <= pwdata;
          REG_OUT_MAP: out_map_q <= pwdata & 32'h0000_0033;
          default: begin
          end
        endcase
      end
    end
  end

  // APB read data, no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (rd_en) begin
        case (paddr)
          REG_CTRL: prdata <= ctrl_q;
          REG_IN_CFG: prdata <= in_cfg_q;
          REG_LEAD: prdata <= lead_q;
          REG_HOLD: prdata <= hold_q;
          REG_MEAS: prdata <= meas_q;
          REG_CAL_INT: prdata <= cal_int_q;
          REG_CLN_INT: prdata <= cln_int_q;
          REG_ACT_LEN: prdata <= act_len_q;
          REG_STATUS: prdata <= {18'h0, kind1, kind0, busy, samp_r, meas_a, in_act[1:0], access};
          REG_OUT_MAP: prdata <= out_map_q;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign start_ch = {start_q & ctrl_q[CTRL_CH2], start_q};

  // One sequencer per measuring channel
  for (genvar c = 0; c < 2; c++) begin : g_ch
    sag_chan u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_q),
      .run_en(ctrl_q[CTRL_RUN] & (c == 0 || ctrl_q[CTRL_CH2])),
      .cont_mode(ctrl_q[CTRL_CONT]),
      .start_req(start_ch[c]),
      .access(access[c]),
      .lead_us(lead_q),
      .hold_us(hold_q),
      .meas_us(meas_q),
      .cal_int_us(cal_int_q),
      .cln_int_us(cln_int_q),
      .act_len_us(act_len_q),
      .meas_active(meas_a[c]),
      .sample_req(samp_r[c]),
      .busy(busy[c]),
      .act_kind(kinds[2*c +: 2])
    );
  end
  // Activity kind of each channel for the status word
  assign kind0 = kinds[1:0];
  assign kind1 = kinds[3:2];

  // Status sources: 0 meas ch1, 1 request ch1, 2 meas ch2, 3 request ch2
  assign src = {samp_r[1], meas_a[1], samp_r[0], meas_a[0]};

  // Output routing per binary output
  for (genvar o = 0; o < NUM_OUT; o++) begin : g_out
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bin_out[o] <= 1'b0;
      end else begin
        bin_out[o] <= src[out_map_q[4*o +: 2]];
      end
    end
  end
endmodule : sag_top
`default_nettype wire

// File: tb/sag_sva.sv
// Purpose: Port checker for the gating sequencer
// Assumes: Output 0 shows measuring, output 1 the sample request
// Notes: Shadows written registers from the APB port
`default_nettype none
module sag_sva
  import sag_pkg::*;
#(
  parameter int unsigned NUM_IN = 2,
  parameter int unsigned NUM_OUT = 2
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Binary lines
  input wire logic [NUM_IN-1:0] bin_in,
  input wire logic [NUM_OUT-1:0] bin_out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SL = TICK_CYCLES + 8;
  logic [31:0] cfg_q, lead_q, hold_q, meas_q, map_q, cap;
  logic sel, off, map_ok, req_q;
  int unsigned off_n, age_n;
  // Access inactive on the selected enabled input
  assign sel = cfg_q[IN_SEL_CH0];
  assign off = cfg_q[2*sel] && (bin_in[sel] != cfg_q[2*sel+1]);
  assign map_ok = (map_q[7:0] == 8'h10);
  assign cap = TICK_CYCLES * ((hold_q < lead_q + meas_q) ? hold_q : lead_q + meas_q);
  // Shadow copies of written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= IN_CFG_RESET;
      lead_q <= LEAD_RESET;
      hold_q <= HOLD_RESET;
      meas_q <= MEAS_RESET;
      map_q <= OUT_MAP_RESET;
    end else if (psel && penable && pwrite && pready && !pslverr) begin
      case (paddr)
        REG_IN_CFG: cfg_q <= pwdata;
        REG_LEAD: lead_q <= pwdata;
        REG_HOLD: hold_q <= pwdata;
        REG_MEAS: meas_q <= pwdata;
        REG_OUT_MAP: map_q <= pwdata;
        default: ;
      endcase
    end
  end
  // Age of the request and of the access loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 1'b0;
      age_n <= 0;
      off_n <= 0;
    end else begin
      req_q <= bin_out[1];
      age_n <= (bin_out[1] && !req_q) ? 1 : age_n + 1;
      off_n <= !off ? 0 : (off_n < 99 ? off_n + 1 : off_n);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  pready_single_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside one access cycle");
  err_unmapped_a: assert property (pready && (paddr > REG_OUT_MAP || paddr[1:0] != 2'b00)
    |-> pslverr) else $error("unmapped access not refused");
  err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
    else $error("refused read not zero");
  lead_readback_a: assert property (pready && !pwrite && paddr == REG_LEAD |-> prdata == lead_q)
    else $error("lead time readback wrong");
  reset_quiet_a: assert property (disable iff (1'b0) !presetn ##1 !presetn |->
    bin_out == '0 && !pready)
    else $error("outputs active in reset");
  req_gated_a: assert property ($rose(bin_out[1]) && map_ok |-> off_n < 12)
    else $error("request without access");
  req_lead_a: assert property ($rose(bin_out[0]) && map_ok |->
    age_n + SL >= lead_q * TICK_CYCLES && age_n <= lead_q * TICK_CYCLES + SL)
    else $error("measurement not one lead after request");
  req_hold_a: assert property ($fell(bin_out[1]) && map_ok |->
    age_n + SL >= cap && age_n <= cap + SL) else $error("request length wrong");
  cover property (map_ok && $rose(bin_out[0]));
  cover property (pready && pslverr);
  cover property (map_ok && $fell(bin_out[1]));
endmodule // sag_sva
bind sag_top sag_sva #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) sva_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bin_in(bin_in), .bin_out(bin_out));
`default_nettype wire

// File: tb/sag_pump_model.sv
// Purpose: External controller driving the access line
// Assumes: Measuring status comes back on a binary output
// Notes: One-shot mode drops access during the measurement
`default_nettype none
module sag_pump_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic want,
  input wire logic one_shot,
  input wire logic pol,
  // Device status
  input wire logic meas,
  // Access line
  output logic acc_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic drop_q;
  // Drop access once a single measurement runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= want && (drop_q || (one_shot && meas));
    end
  end
  // Active level follows chosen polarity
  assign acc_pin = (want && !drop_q) ? pol : !pol;
endmodule // sag_pump_model
`default_nettype wire

// File: tb/sample_activity_gating_sequencer_test.sv
// Purpose: Self-checking bench for the gating sequencer
// Assumes: Controller model drives input 0, input 1 held low
// Notes: Short times, checked within one tick plus 8 cycles
`default_nettype none
module sample_activity_gating_sequencer_test
  import sag_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned SL = TICK_CYCLES + 8;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE = 32'h0000_0001;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
    logic err;
  } sag_row_type;
  localparam sag_row_type ROWS [14] = '{
    '{1'b0, REG_CTRL, ZERO, ZERO, 1'b0},
    '{1'b0, REG_IN_CFG, ZERO, IN_CFG_RESET, 1'b0},
    '{1'b0, REG_LEAD, ZERO, LEAD_RESET, 1'b0},
    '{1'b0, REG_HOLD, ZERO, HOLD_RESET, 1'b0},
    '{1'b0, REG_MEAS, ZERO, MEAS_RESET, 1'b0},
    '{1'b0, REG_CAL_INT, ZERO, CAL_INT_RESET, 1'b0},
    '{1'b0, REG_CLN_INT, ZERO, CLN_INT_RESET, 1'b0},
    '{1'b0, REG_ACT_LEN, ZERO, ACT_LEN_RESET, 1'b0},
    '{1'b0, REG_OUT_MAP, ZERO, OUT_MAP_RESET, 1'b0},
    '{1'b0, 8'h28, ZERO, ZERO, 1'b1},
    '{1'b1, 8'h28, ONE, ZERO, 1'b1},
    '{1'b0, 8'h0A, ZERO, ZERO, 1'b1},
    '{1'b1, REG_LEAD, 32'h0000_0002, ZERO, 1'b0},
    '{1'b0, REG_LEAD, ZERO, 32'h0000_0002, 1'b0}
  };
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic want, one_shot, pol, acc_pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] bin_in, bin_out;
  int errors = 0;
  int checks_done = 0;
  int n;
  assign bin_in = {1'b0, acc_pin};
  // Device and external controller
  sag_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bin_in(bin_in), .bin_out(bin_out));
  sag_pump_model pump_u (
    .pclk(pclk), .presetn(presetn), .want(want), .one_shot(one_shot), .pol(pol),
    .meas(bin_out[0]), .acc_pin(acc_pin));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic near(input int k, input int unsigned us);
    chk(32'(k + SL >= us * TICK_CYCLES && k <= us * TICK_CYCLES + SL), ONE);
  endtask
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 40) begin
      chk(ONE, ZERO);
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic wait_out(input int i, input logic v, input int max);
    n = 0;
    while (bin_out[i] !== v && n < max) begin
      @(posedge pclk);
      n++;
    end
    if (n >= max) begin
      chk(ONE, ZERO);
      end_sim();
    end
  endtask
  task automatic quiet(input int i, input int cyc);
    int bad;
    bad = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (bin_out[i] !== 1'b0) bad++;
    end
    chk(32'(bad), ZERO);
  endtask
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, want, one_shot} = '0;
    pol = 1'b1;
    paddr = 8'h00;
    pwdata = ZERO;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[k]) begin
      apb(ROWS[k].wr, ROWS[k].addr, ROWS[k].data);
      chk(32'(err), 32'(ROWS[k].err));
      if (!ROWS[k].wr) begin
        chk(rd, ROWS[k].exp);
      end
    end
    wr(REG_HOLD, 32'h0000_0002);
    wr(REG_MEAS, 32'h0000_0003);
    wr(REG_ACT_LEN, 32'h0000_0002);
    wr(REG_OUT_MAP, 32'h0000_0010);
    wr(REG_CTRL, 32'h0000_0003);
    quiet(1, 2000);
    want <= 1'b1;
    wait_out(1, 1'b1, 40);
    chk(32'(n >= 5), ONE);
    wait_out(0, 1'b1, 2000);
    near(n, 2);
    wait_out(0, 1'b0, 2000);
    near(n, 3);
    wait_out(1, 1'b1, 20);
    // Single measurement, access dropped while it runs
    one_shot <= 1'b1;
    wait_out(0, 1'b1, 2000);
    wait_out(0, 1'b0, 2000);
    near(n, 3);
    quiet(1, 2000);
    want <= 1'b0;
    // Due calibration goes before the measurement
    wr(REG_CAL_INT, ONE);
    quiet(1, 400);
    want <= 1'b1;
    wait_out(1, 1'b1, 40);
    wait_out(1, 1'b0, 2000);
    near(n, 2);
    quiet(0, 200);
    wait_out(1, 1'b1, 2000);
    near(n + 200, 2);
    chk(32'(bin_out[0]), ZERO);
    wait_out(0, 1'b1, 2000);
    near(n, 2);
    wait_out(0, 1'b0, 2000);
    want <= 1'b0;
    wr(REG_CAL_INT, CAL_INT_RESET);
    // Enable and low-active polarity
    wr(REG_CTRL, ZERO);
    pol <= 1'b0;
    wr(REG_IN_CFG, 32'h0000_1000);
    want <= 1'b1;
    apb(1'b0, REG_STATUS, ZERO);
    chk(32'(rd[2]), ZERO);
    wr(REG_IN_CFG, 32'h0000_1001);
    apb(1'b0, REG_STATUS, ZERO);
    chk(32'(rd[2]), ONE);
    wr(REG_CTRL, 32'h0000_0003);
    wait_out(1, 1'b1, 40);
    wait_out(0, 1'b1, 4000);
    wait_out(0, 1'b0, 1000);
    // Second channel on input 0, its status routed out, one start pulse only
    wr(REG_CTRL, ZERO);
    wr(REG_IN_CFG, 32'h0000_0101);
    wr(REG_OUT_MAP, 32'h0000_0032);
    want <= 1'b0;
    @(posedge pclk);
    one_shot <= 1'b0;
    want <= 1'b1;
    wr(REG_CTRL, 32'h0000_000D);
    wait_out(1, 1'b1, 40);
    wait_out(0, 1'b1, 2000);
    wait_out(0, 1'b0, 2000);
    quiet(1, 1000);
    // Reset in mid-run
    wr(REG_CTRL, 32'h0000_0007);
    wait_out(1, 1'b1, 40);
    presetn <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    chk(32'(bin_out), ZERO);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, ZERO);
    chk(rd, ZERO);
    end_sim();
  end
endmodule // sample_activity_gating_sequencer_test
`default_nettype wire
